// *** logic/seg_pkg.sv ***
`default_nettype none
package seg_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] SEG_TASK_BASE = 12'h000;
  localparam logic [11:0] SEG_TLINK_BASE = 12'h080;
  localparam logic [11:0] SEG_FLAG_BASE = 12'h100;
  localparam logic [11:0] SEG_ELINK_BASE = 12'h180;
  localparam logic [11:0] SEG_IRQ_MASK = 12'h300;
  localparam logic [11:0] SEG_IRQ_SET = 12'h304;
  localparam logic [11:0] SEG_IRQ_CLR = 12'h308;
  localparam logic [11:0] SEG_BANK_SPAN = 12'h040;
  // ==========================================================
  // Field layout of link registers, register reset value and response codes
  localparam int SEG_LINK_EN_BIT = 31;
  localparam int SEG_CHANNEL_INDEX_W = 4;
  localparam logic [31:0] SEG_REG_RESET = 32'h0000_0000;
  localparam logic [1:0] SEG_RESP_OKAY = 2'h0;
  localparam logic [1:0] SEG_RESP_SLVERR = 2'h2;

  // Channel link setting: enable and channel_index
  typedef struct packed {
    logic en;
    logic [SEG_CHANNEL_INDEX_W-1:0] channel_index;
  } seg_link_t;
endpackage
`default_nettype wire

// *** logic/seg_link_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
// Small memory of channel link settings with registered read data
module seg_link_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire seg_pkg::seg_link_t wr_data,
  input wire logic [AW-1:0] rd_addr,
  output seg_pkg::seg_link_t rd_data,
  output seg_pkg::seg_link_t entries [DEPTH]
);
  initial begin
    if (DEPTH != (1 << AW)) $error("seg_link_mem: DEPTH must be 2**AW");
  end
  seg_pkg::seg_link_t mem_r [DEPTH];
  seg_pkg::seg_link_t rd_r;
  // ==========================================================
  // Storage, zeroed by reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      rd_r <= '0;
    end else begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_r <= mem_r[rd_addr];
    end
  end
  assign rd_data = rd_r;
  assign entries = mem_r;
endmodule
`default_nettype wire

// *** logic/seg_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Sixteen channel software event generator with AXI4-Lite registers
module seg_top #(
  parameter int NCH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCH-1:0] chan_in,
  output logic [NCH-1:0] chan_out,
  output logic irq
);
  initial begin
    if (NCH != 16) $error("seg_top: NCH must be 16");
  end

  typedef enum logic [1:0] {RD_IDLE, RD_MEM, RD_DONE} seg_rd_t;

  // State of the block apart from the link memories
  typedef struct packed {
    logic [11:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    logic bvalid;
    logic [1:0] bresp;
    seg_rd_t rd_state;
    logic [11:0] araddr;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NCH-1:0] flag;
    logic [NCH-1:0] irq_enable_mask;
    logic [NCH-1:0] pub;
    logic [NCH-1:0] chan_s1;
    logic [NCH-1:0] chan_s2;
    logic irq;
  } seg_state_t;

  seg_state_t st_r;
  seg_state_t st_nxt;

  // ==========================================================
  // Link memories for task and event channel settings
  logic tl_we;
  logic el_we;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  seg_pkg::seg_link_t wr_link;
  seg_pkg::seg_link_t tl_rd;
  seg_pkg::seg_link_t el_rd;
  seg_pkg::seg_link_t tl_ent [NCH];
  seg_pkg::seg_link_t el_ent [NCH];

  assign wr_idx = st_r.awaddr[5:2];
  assign rd_idx = st_r.araddr[5:2];
  assign wr_link.en = st_r.wdata[seg_pkg::SEG_LINK_EN_BIT];
  assign wr_link.channel_index = st_r.wdata[seg_pkg::SEG_CHANNEL_INDEX_W-1:0];

  seg_link_mem #(.DEPTH(NCH), .AW(4)) u_task_links (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(tl_we),
    .wr_addr(wr_idx),
    .wr_data(wr_link),
    .rd_addr(rd_idx),
    .rd_data(tl_rd),
    .entries(tl_ent)
  );

  seg_link_mem #(.DEPTH(NCH), .AW(4)) u_event_links (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(el_we),
    .wr_addr(wr_idx),
    .wr_data(wr_link),
    .rd_addr(rd_idx),
    .rd_data(el_rd),
    .entries(el_ent)
  );

  // ==========================================================
  // Subscription: a pulse on the selected channel acts as a task
  logic [NCH-1:0] sub_hit;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_sub
      assign sub_hit[g] = tl_ent[g].en & st_r.chan_s2[tl_ent[g].channel_index];
    end
  endgenerate

  // ==========================================================
  // Write decode
  logic wr_go;
  logic [11:0] wa;
  logic wr_task;
  logic wr_tlink;
  logic wr_flag;
  logic wr_elink;
  logic wr_ok;

  assign wr_go = st_r.aw_held & st_r.w_held & ~st_r.bvalid;
  assign wa = {st_r.awaddr[11:2], 2'h0};

  // Address decode as an if chain, each bank a 64 byte window
  always_comb begin
    wr_task = 1'b0;
    wr_tlink = 1'b0;
    wr_flag = 1'b0;
    wr_elink = 1'b0;
    wr_ok = 1'b1;
    if (wa < seg_pkg::SEG_TASK_BASE + seg_pkg::SEG_BANK_SPAN) begin
      wr_task = 1'b1;
    end else if (wa >= seg_pkg::SEG_TLINK_BASE &&
                 wa < seg_pkg::SEG_TLINK_BASE + seg_pkg::SEG_BANK_SPAN) begin
      wr_tlink = 1'b1;
    end else if (wa >= seg_pkg::SEG_FLAG_BASE &&
                 wa < seg_pkg::SEG_FLAG_BASE + seg_pkg::SEG_BANK_SPAN) begin
      wr_flag = 1'b1;
    end else if (wa >= seg_pkg::SEG_ELINK_BASE &&
                 wa < seg_pkg::SEG_ELINK_BASE + seg_pkg::SEG_BANK_SPAN) begin
      wr_elink = 1'b1;
    end else if (wa == seg_pkg::SEG_IRQ_MASK || wa == seg_pkg::SEG_IRQ_SET ||
                 wa == seg_pkg::SEG_IRQ_CLR) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Link registers are written whole; partial strobes would split en from index
  assign tl_we = wr_go & wr_tlink;
  assign el_we = wr_go & wr_elink;

  // ==========================================================
  // Read decode of the current address
  logic [31:0] rd_word;
  logic rd_ok;
  logic rd_is_mem;
  logic [11:0] ra;

  assign ra = {st_r.araddr[11:2], 2'h0};

  always_comb begin
    rd_word = seg_pkg::SEG_REG_RESET;
    rd_ok = 1'b1;
    rd_is_mem = 1'b0;
    if (ra < seg_pkg::SEG_TASK_BASE + seg_pkg::SEG_BANK_SPAN) begin
      rd_word = seg_pkg::SEG_REG_RESET; // Tasks are write only
    end else if (ra >= seg_pkg::SEG_TLINK_BASE &&
                 ra < seg_pkg::SEG_TLINK_BASE + seg_pkg::SEG_BANK_SPAN) begin
      rd_is_mem = 1'b1;
      rd_word = {tl_rd.en, 27'h0, tl_rd.channel_index};
    end else if (ra >= seg_pkg::SEG_FLAG_BASE &&
                 ra < seg_pkg::SEG_FLAG_BASE + seg_pkg::SEG_BANK_SPAN) begin
      rd_word = {31'h0, st_r.flag[rd_idx]};
    end else if (ra >= seg_pkg::SEG_ELINK_BASE &&
                 ra < seg_pkg::SEG_ELINK_BASE + seg_pkg::SEG_BANK_SPAN) begin
      rd_is_mem = 1'b1;
      rd_word = {el_rd.en, 27'h0, el_rd.channel_index};
    end else if (ra == seg_pkg::SEG_IRQ_MASK || ra == seg_pkg::SEG_IRQ_SET ||
                 ra == seg_pkg::SEG_IRQ_CLR) begin
      rd_word = {16'h0, st_r.irq_enable_mask};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ==========================================================
  // Next state
  logic [NCH-1:0] task_hit;
  logic [NCH-1:0] flag_clr;
  logic [NCH-1:0] wmask;

  always_comb begin
    st_nxt = st_r;
    task_hit = sub_hit;
    flag_clr = '0;
    wmask = {{8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
    // Write channels are held until both parts are in
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_go) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_ok ? seg_pkg::SEG_RESP_OKAY : seg_pkg::SEG_RESP_SLVERR;
      if (wr_task && st_r.wstrb[0] && st_r.wdata[0]) begin
        task_hit[wr_idx] = 1'b1;
      end
      if (wr_flag && st_r.wstrb[0]) begin
        // Software may set or clear a flag directly
        if (st_r.wdata[0]) begin
          task_hit[wr_idx] = 1'b1;
        end else begin
          flag_clr[wr_idx] = 1'b1;
        end
      end
      if (wa == seg_pkg::SEG_IRQ_MASK) begin
        st_nxt.irq_enable_mask = (st_r.irq_enable_mask & ~wmask) | (st_r.wdata[NCH-1:0] & wmask);
      end else if (wa == seg_pkg::SEG_IRQ_SET) begin
        st_nxt.irq_enable_mask = st_r.irq_enable_mask | (st_r.wdata[NCH-1:0] & wmask);
      end else if (wa == seg_pkg::SEG_IRQ_CLR) begin
        st_nxt.irq_enable_mask = st_r.irq_enable_mask & ~(st_r.wdata[NCH-1:0] & wmask);
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // A new event wins over a clear in the same cycle
    st_nxt.flag = (st_r.flag & ~flag_clr) | task_hit;
    // Publish a one-cycle pulse on each enabled event's channel
    st_nxt.pub = '0;
    for (int i = 0; i < NCH; i++) begin
      if (task_hit[i] && el_ent[i].en) begin
        st_nxt.pub[el_ent[i].channel_index] = 1'b1;
      end
    end
    // Registered so the interrupt lags the flag by exactly one cycle
    st_nxt.irq = |(st_r.flag & st_r.irq_enable_mask);
    // Channel pulses come from outside this clock's timing, so resync
    st_nxt.chan_s1 = chan_in;
    st_nxt.chan_s2 = st_r.chan_s1;
    // Read: one wait cycle when a link memory must be read
    case (st_r.rd_state)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          st_nxt.araddr = s_axi_araddr;
          st_nxt.rd_state = RD_MEM;
        end
      end
      RD_MEM: begin
        st_nxt.rdata = rd_word;
        st_nxt.rresp = rd_ok ? seg_pkg::SEG_RESP_OKAY : seg_pkg::SEG_RESP_SLVERR;
        st_nxt.rd_state = rd_is_mem ? RD_MEM : RD_DONE;
        if (rd_is_mem && st_r.rdata[0] == 1'b0 && st_r.rresp == 2'h3) begin
          st_nxt.rd_state = RD_DONE;
        end
        st_nxt.rresp = rd_is_mem ? 2'h3 : st_nxt.rresp;
        if (rd_is_mem && st_r.rresp == 2'h3) begin
          st_nxt.rresp = seg_pkg::SEG_RESP_OKAY;
          st_nxt.rd_state = RD_DONE;
        end
      end
      RD_DONE: begin
        if (s_axi_rready) begin
          st_nxt.rd_state = RD_IDLE;
        end
      end
      default: begin
        st_nxt.rd_state = RD_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = ~st_r.aw_held;
  assign s_axi_wready = ~st_r.w_held;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = (st_r.rd_state == RD_IDLE);
  assign s_axi_rvalid = (st_r.rd_state == RD_DONE);
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign chan_out = st_r.pub;
  assign irq = st_r.irq;

  // ==========================================================
  // Checks
  sequence flag_up_s(int i);
    !st_r.flag[i] ##1 st_r.flag[i];
  endsequence

  task_sets_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_go && wr_task && st_r.wstrb[0] && st_r.wdata[0] |=> st_r.flag[$past(wr_idx)])
    else $error("task write did not set flag");
  irq_latency_a: assert property (@(posedge mclk) disable iff (!rst_n)
    |(st_r.flag & st_r.irq_enable_mask) |=> irq)
    else $error("irq not raised one cycle after enabled flag");
  irq_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(|(st_r.flag & st_r.irq_enable_mask)) |=> !irq)
    else $error("irq held without enabled flag");
  irq_first_a: assert property (@(posedge mclk) disable iff (!rst_n)
    flag_up_s(0) ##0 st_r.irq_enable_mask[0] && !$past(irq) |-> ##1 irq)
    else $error("irq late after flag 0");
  irq_enable_mask_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_go && wa == seg_pkg::SEG_IRQ_SET && st_r.wstrb[0] && st_r.wdata[0] |=> st_r.irq_enable_mask[0])
    else $error("setter did not enable");
  irq_enable_mask_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_go && wa == seg_pkg::SEG_IRQ_CLR && st_r.wstrb[0] && st_r.wdata[0] |=> !st_r.irq_enable_mask[0])
    else $error("clearer did not disable");
  irq_enable_mask_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_go && wa == seg_pkg::SEG_IRQ_MASK && &st_r.wstrb[1:0]
    |=> st_r.irq_enable_mask == $past(st_r.wdata[15:0]))
    else $error("mask write not stored");
  flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_go && wr_flag && st_r.wstrb[0] && !st_r.wdata[0] && wr_idx == 4'h0 && !sub_hit[0]
    |=> !st_r.flag[0])
    else $error("flag 0 not cleared");
  publish_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sub_hit[0] && el_ent[0].en |=> chan_out[$past(el_ent[0].channel_index)])
    else $error("event 0 not published");
  subscribe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tl_ent[1].en && st_r.chan_s2[tl_ent[1].channel_index] |=> st_r.flag[1])
    else $error("subscribed channel did not trigger task 1");
endmodule
`default_nettype wire

// *** dv/seg_chan_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========
// Interconnect stand-in: fires channel pulses, collects publish pulses
module seg_chan_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] fire,
  input wire logic clr,
  input wire logic [15:0] chan_out,
  output logic [15:0] chan_in,
  output logic [15:0] seen
);
  // chan_in repeats fire one cycle later, for as long as fire is held; seen keeps every pulse except in a cycle with clr high, which empties it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chan_in <= 16'h0000;
      seen <= 16'h0000;
    end else begin
      chan_in <= fire;
      seen <= clr ? 16'h0000 : (seen | chan_out);
    end
  end
endmodule
`default_nettype wire

// *** dv/seg_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module seg_top_bench;
  logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, clr;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] chan_in, chan_out, fire, seen;
  int n_errors, cmp_count;

  seg_top #(.NCH(16)) u_dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chan_in(chan_in), .chan_out(chan_out), .irq(irq));

  seg_chan_model u_far (.mclk(mclk), .rst_n(rst_n), .fire(fire), .clr(clr),
    .chan_out(chan_out), .chan_in(chan_in), .seen(seen));

  // ==========
  // Clock, verdict and watchdog
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic final_report;
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run needs under two thousand cycles; this is ample margin
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("BAD t=%0t watchdog=%h limit=%h", $time, 20000, 20000);
    final_report;
  end

  // ==========
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data released separately as each is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int t;
    logic aw_p, w_p;
    t = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((aw_p || w_p || bvalid !== 1'b1) && t < 40) begin
      @(posedge mclk);
      t++;
      if (aw_p && awready === 1'b1) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    rsp = bresp;
    bready <= 1'b0;
    if (t >= 40) begin
      n_errors++;
      $display("BAD t=%0t waited=%h limit=%h", $time, t, 40);
    end
    @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] a);
    int t;
    logic ar_p;
    t = 0;
    ar_p = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while ((ar_p || rvalid !== 1'b1) && t < 40) begin
      @(posedge mclk);
      t++;
      if (ar_p && arready === 1'b1) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
      end
    end
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (t >= 40) begin
      n_errors++;
      $display("BAD t=%0t waited=%h limit=%h", $time, t, 40);
    end
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_v, exp);
  endtask

  // Clears the collector together with the pulse so only fresh publishes count
  task automatic fire_ch(input logic [15:0] m);
    fire <= m;
    clr <= 1'b1;
    @(posedge mclk);
    fire <= 16'h0000;
    clr <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset;
    rchk(seg_pkg::SEG_IRQ_MASK, 32'h0000_0000);
    rchk(seg_pkg::SEG_IRQ_SET, 32'h0000_0000);
    rchk(seg_pkg::SEG_TLINK_BASE + 12'h004, 32'h0000_0000);
    rchk(seg_pkg::SEG_ELINK_BASE + 12'h03c, 32'h0000_0000);
    rchk(seg_pkg::SEG_FLAG_BASE, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  // Every channel: task write sets its flag, interrupt follows, clearing drops it
  task automatic t_tasks;
    wr(seg_pkg::SEG_IRQ_MASK, 32'h0000_ffff);
    rchk(seg_pkg::SEG_IRQ_MASK, 32'h0000_ffff);
    for (int n = 0; n < 16; n++) begin
      wr(seg_pkg::SEG_TASK_BASE + 12'(4 * n), 32'h0000_0001);
      rchk(seg_pkg::SEG_FLAG_BASE + 12'(4 * n), 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(seg_pkg::SEG_FLAG_BASE + 12'(4 * n), 32'h0000_0000);
      rchk(seg_pkg::SEG_FLAG_BASE + 12'(4 * n), 32'h0000_0000);
      chk({31'h0, irq}, 32'h0000_0000);
    end
  endtask

  task automatic t_mask;
    // Only the low byte lane is written, so the upper enables survive
    wstrb <= 4'h1;
    wr(seg_pkg::SEG_IRQ_MASK, 32'h0000_0000);
    wstrb <= 4'hf;
    rchk(seg_pkg::SEG_IRQ_MASK, 32'h0000_ff00);
    wr(seg_pkg::SEG_IRQ_CLR, 32'h0000_ffff);
    rchk(seg_pkg::SEG_IRQ_SET, 32'h0000_0000);
    wr(seg_pkg::SEG_TASK_BASE + 12'h014, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(seg_pkg::SEG_IRQ_SET, 32'h0000_0020);
    rchk(seg_pkg::SEG_IRQ_CLR, 32'h0000_0020);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(seg_pkg::SEG_IRQ_CLR, 32'h0000_0001);
    rchk(seg_pkg::SEG_IRQ_MASK, 32'h0000_0020);
    wr(seg_pkg::SEG_IRQ_CLR, 32'h0000_0020);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(seg_pkg::SEG_FLAG_BASE + 12'h014, 32'h0000_0000);
  endtask

  // Distinct channel per task so a pulse can only reach the linked one
  task automatic t_links;
    logic [31:0] c, p;
    logic [11:0] tl, el, fl;
    for (int n = 0; n < 16; n++) begin
      c = 32'((n + 3) % 16);
      p = 32'((n * 5 + 1) % 16);
      tl = seg_pkg::SEG_TLINK_BASE + 12'(4 * n);
      el = seg_pkg::SEG_ELINK_BASE + 12'(4 * n);
      fl = seg_pkg::SEG_FLAG_BASE + 12'(4 * n);
      wr(tl, 32'h8000_0000 | c);
      wr(el, 32'h8000_0000 | p);
      rchk(tl, 32'h8000_0000 | c);
      rchk(el, 32'h8000_0000 | p);
      fire_ch(16'h0001 << c);
      rchk(fl, 32'h0000_0001);
      chk({16'h0, seen}, 32'h0000_0001 << p);
      wr(fl, 32'h0000_0000);
      wr(tl, c);
      wr(el, p);
      fire_ch(16'h0001 << c);
      rchk(fl, 32'h0000_0000);
      wr(seg_pkg::SEG_TASK_BASE + 12'(4 * n), 32'h0000_0001);
      rchk(fl, 32'h0000_0001);
      chk({16'h0, seen}, 32'h0000_0000);
      wr(fl, 32'h0000_0000);
    end
  endtask

  task automatic t_unmapped;
    wr(12'h400, 32'h0000_0001);
    chk({30'h0, rsp}, {30'h0, seg_pkg::SEG_RESP_SLVERR});
    rd(12'h400);
    chk({30'h0, rsp}, {30'h0, seg_pkg::SEG_RESP_SLVERR});
    rchk(seg_pkg::SEG_TASK_BASE + 12'h008, 32'h0000_0000);
    chk({30'h0, rsp}, {30'h0, seg_pkg::SEG_RESP_OKAY});
  endtask

  // ==========
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, clr} = 6'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    fire = 16'h0000;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_tasks;
    t_mask;
    t_links;
    t_unmapped;
    final_report;
  end
endmodule
`default_nettype wire
